// >>> verilog/bscl_pkg.sv
// package for the boot strap configuration latch: strap decode constants and carriers
// assumes strap pins are asynchronous board levels, synchronised in the top module
// Operation
// - sample both boot-source straps; both high boots internal flash; download source never entered
// - timing_a/message straps: LL fall/fall, LH rise-in fall-out, HL fall-in rise-out, HH rise/rise
// - apply the decoded sampling and driving edges to the slave port during boot
// - message strap high enables uart boot messages; board holds it low to suppress
// - voltage strap low selects 3.3V signalling; 1.8V high level is never entered
// - shared pin group routes to exactly one of sdio, spi or gpio by host command
package bscl_pkg;
	localparam int BSCL_SYNC_STAGES = 2;
	localparam logic [1:0] BSCL_STRAP_BOOT_FLASH = 2'h3;
	localparam logic BSCL_EDGE_RISING = 1'h1;
	localparam logic BSCL_EDGE_FALLING = 1'h0;
	localparam logic BSCL_VOLT_3V3 = 1'h0;
	localparam logic [2:0] BSCL_ROUTE_GPIO_ONEHOT = 3'h4;

	typedef enum logic [1:0] {
		BSCL_BOOT_INTERNAL_FLASH = 2'h0,
		BSCL_BOOT_INVALID = 2'h1
	} bscl_boot_type;

	typedef enum logic [1:0] {
		BSCL_FN_SDIO = 2'h0,
		BSCL_FN_SPI = 2'h1,
		BSCL_FN_GPIO = 2'h2
	} bscl_fn_type;

	typedef enum logic [1:0] {
		BSCL_ST_RESET = 2'h0,
		BSCL_ST_SETTLE = 2'h1,
		BSCL_ST_HELD = 2'h3
	} bscl_state_type;

	typedef struct packed {
		logic boot_src0;
		logic boot_src1;
		logic timing_a;
		logic boot_message_strap;
		logic voltage_select_pin;
	} bscl_straps_type;

	typedef struct packed {
		bscl_boot_type boot_source;
		logic sdio_in_rising;
		logic sdio_out_rising;
		logic uart_boot_msg_en;
		logic volt_1v8_requested;
		logic boot_strap_error;
	} bscl_config_type;

	function automatic bscl_config_type bscl_decode(input bscl_straps_type s);
		bscl_config_type c;
		c.boot_source = ({s.boot_src1, s.boot_src0} == BSCL_STRAP_BOOT_FLASH) ?
			BSCL_BOOT_INTERNAL_FLASH : BSCL_BOOT_INVALID;
		c.sdio_in_rising = s.boot_message_strap;
		c.sdio_out_rising = s.timing_a;
		c.uart_boot_msg_en = s.boot_message_strap;
		c.volt_1v8_requested = (s.voltage_select_pin != BSCL_VOLT_3V3);
		c.boot_strap_error = (c.boot_source != BSCL_BOOT_INTERNAL_FLASH) || c.volt_1v8_requested;
		return c;
	endfunction : bscl_decode
endpackage : bscl_pkg

// >>> verilog/bscl_sync.sv
// two flop synchroniser for the strap pins
// assumes pins are asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module bscl_sync
	import bscl_pkg::*;
#(
	parameter int WIDTH = 5
)
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] out_reg;
	logic [WIDTH-1:0] out_next;

	always_comb
	begin
		meta_next = meta_reg;
		out_next = out_reg;
		if (ce)
		begin
			meta_next = async_in;
			out_next = meta_reg;
		end
	end

	// no reset here: the stages keep sampling through reset, so the capture two
	// edges after release sees live strap levels and not a cleared pipeline
	always_ff @(posedge clk)
	begin
		meta_reg <= meta_next;
		out_reg <= out_next;
	end

	assign sync_out = out_reg;
endmodule : bscl_sync
`default_nettype wire

// >>> verilog/bscl_top.sv
// boot strap configuration latch: captures straps after reset release, holds the
// decoded boot configuration and routes the shared pin group by host command
// assumes one clock, synchronous active low reset, host command from clk domain
`timescale 1ns/1ps
`default_nettype none
module bscl_top
	import bscl_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic boot_src0_pin,
	input wire logic boot_src1_pin,
	input wire logic timing_a_pin,
	input wire logic boot_message_strap,
	input wire logic voltage_select_pin,
	input wire logic boot_active,
	input wire logic fn_sel_valid,
	input wire logic [1:0] fn_sel,
	output logic config_valid,
	output logic boot_from_flash,
	output logic sdio_in_rising,
	output logic sdio_out_rising,
	output logic sdio_edge_apply,
	output logic uart_boot_msg_en,
	output logic sdio_volt_1v8,
	output logic strap_error,
	output logic route_sdio,
	output logic route_spi,
	output logic route_gpio
);
	bscl_straps_type pins_async;
	bscl_straps_type pins_sync;
	bscl_state_type state_reg;
	bscl_state_type state_next;
	bscl_config_type cfg_reg;
	bscl_config_type cfg_next;
	bscl_fn_type fn_reg;
	bscl_fn_type fn_next;

	assign pins_async = '{boot_src0: boot_src0_pin, boot_src1: boot_src1_pin, timing_a: timing_a_pin,
		boot_message_strap: boot_message_strap, voltage_select_pin: voltage_select_pin};

	bscl_sync #(.WIDTH($bits(bscl_straps_type))) u_sync (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.async_in(pins_async),
		.sync_out(pins_sync)
	);

	// capture happens two edges after release, from synchroniser samples taken during reset
	always_comb
	begin
		state_next = state_reg;
		cfg_next = cfg_reg;
		if (ce)
		begin
			case (state_reg)
				BSCL_ST_RESET: state_next = BSCL_ST_SETTLE;
				BSCL_ST_SETTLE:
				begin
					state_next = BSCL_ST_HELD;
					cfg_next = bscl_decode(pins_sync);
				end
				BSCL_ST_HELD: state_next = BSCL_ST_HELD;
				default: state_next = BSCL_ST_RESET;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			state_reg <= BSCL_ST_RESET;
			cfg_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			cfg_reg <= cfg_next;
		end
	end

	// unknown codes are ignored so exactly one function stays routed
	always_comb
	begin
		fn_next = fn_reg;
		if (ce && fn_sel_valid && (fn_sel == BSCL_FN_SDIO || fn_sel == BSCL_FN_SPI || fn_sel == BSCL_FN_GPIO))
		begin
			fn_next = bscl_fn_type'(fn_sel);
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			fn_reg <= BSCL_FN_GPIO;
		else
			fn_reg <= fn_next;
	end

	assign config_valid = (state_reg == BSCL_ST_HELD);
	assign boot_from_flash = config_valid && (cfg_reg.boot_source == BSCL_BOOT_INTERNAL_FLASH);
	assign sdio_in_rising = cfg_reg.sdio_in_rising;
	assign sdio_out_rising = cfg_reg.sdio_out_rising;
	assign sdio_edge_apply = config_valid && boot_active;
	assign uart_boot_msg_en = config_valid && cfg_reg.uart_boot_msg_en;
	// a 1.8V request is flagged, never driven out
	assign sdio_volt_1v8 = 1'b0;
	assign strap_error = config_valid && cfg_reg.boot_strap_error;
	assign route_sdio = (fn_reg == BSCL_FN_SDIO);
	assign route_spi = (fn_reg == BSCL_FN_SPI);
	assign route_gpio = (fn_reg == BSCL_FN_GPIO);

	logic held_d;
	always_ff @(posedge clk)
	begin
		if (!nrst)
			held_d <= 1'b0;
		else
			held_d <= config_valid;
	end

	chk_route_onehot: assert property (@(posedge clk) disable iff (!nrst)
		$onehot({route_sdio, route_spi, route_gpio})) else $error("route not one-hot");
	chk_route_cmd: assert property (@(posedge clk) disable iff (!nrst)
		ce && fn_sel_valid && fn_sel == BSCL_FN_SPI |=> route_spi) else $error("spi not routed");
	chk_cfg_stable: assert property (@(posedge clk) disable iff (!nrst)
		held_d |-> $stable(cfg_reg)) else $error("config changed after capture");
	chk_capture_time: assert property (@(posedge clk)
		$rose(nrst) |-> ##2 config_valid) else $error("capture not on time");
	chk_flash_boot: assert property (@(posedge clk) disable iff (!nrst)
		$rose(config_valid) && $past(pins_sync.boot_src0, 1) && $past(pins_sync.boot_src1, 1)
		|-> boot_from_flash) else $error("flash boot missed");
	chk_timing_decode: assert property (@(posedge clk) disable iff (!nrst)
		$rose(config_valid) |-> sdio_in_rising == $past(pins_sync.boot_message_strap, 1)
		&& sdio_out_rising == $past(pins_sync.timing_a, 1)) else $error("timing decode wrong");
	chk_edge_apply: assert property (@(posedge clk) disable iff (!nrst)
		sdio_edge_apply == (config_valid && boot_active)) else $error("edge apply wrong");
	chk_msg_enable: assert property (@(posedge clk) disable iff (!nrst)
		$rose(config_valid) |-> uart_boot_msg_en == $past(pins_sync.boot_message_strap, 1))
		else $error("message enable wrong");
	chk_no_1v8: assert property (@(posedge clk) disable iff (!nrst)
		!sdio_volt_1v8) else $error("1.8V entered");

	cov_flash: cover property (@(posedge clk) disable iff (!nrst) $rose(boot_from_flash));
	cov_error: cover property (@(posedge clk) disable iff (!nrst) $rose(strap_error));
	cov_sdio: cover property (@(posedge clk) disable iff (!nrst) $rose(route_sdio));
	cov_apply: cover property (@(posedge clk) disable iff (!nrst) $rose(sdio_edge_apply));
endmodule : bscl_top
`default_nettype wire

// >>> sim/bscl_strap_model.sv
// board side of the strap pins: internal pulls unless a host drives them
// assumes the host drives only while drive_en is high
`timescale 1ns/1ps
`default_nettype none
module bscl_strap_model
	import bscl_pkg::*;
(
	input wire logic drive_en,
	input wire bscl_straps_type drv,
	output var bscl_straps_type pins
);
	// undriven pins settle to their pulls: boot and timing high, voltage low
	localparam bscl_straps_type PULLS = 5'h1e;
	assign pins = drive_en ? drv : PULLS;
endmodule : bscl_strap_model
`default_nettype wire

// >>> sim/bscl_top_bench.sv
// self-checking bench for the strap latch: decode, hold, edge apply, routing
// assumes straps settle during reset and the host command is clk-synchronous
`timescale 1ns/1ps
`default_nettype none
module bscl_top_bench;
	import bscl_pkg::*;
	logic clk = 0, nrst = 0, ce = 1, drv_en = 0, boot_active = 0, fn_sel_valid = 0;
	logic [1:0] fn_sel = 2'h0;
	bscl_straps_type drv = '0, pins;
	logic config_valid, boot_from_flash, sdio_in_rising, sdio_out_rising, sdio_edge_apply;
	logic uart_boot_msg_en, sdio_volt_1v8, strap_error, route_sdio, route_spi, route_gpio;
	logic [7:0] outs;
	int err_total = 0, num_checks = 0;
	assign outs = {1'b0, config_valid, boot_from_flash, sdio_in_rising, sdio_out_rising,
		uart_boot_msg_en, sdio_volt_1v8, strap_error};
	bscl_strap_model i_bscl_strap_model (.drive_en(drv_en), .drv(drv), .pins(pins));
	bscl_top i_bscl_top (.clk(clk), .nrst(nrst), .ce(ce), .boot_src0_pin(pins.boot_src0),
		.boot_src1_pin(pins.boot_src1), .timing_a_pin(pins.timing_a),
		.boot_message_strap(pins.boot_message_strap), .voltage_select_pin(pins.voltage_select_pin),
		.boot_active(boot_active), .fn_sel_valid(fn_sel_valid), .fn_sel(fn_sel),
		.config_valid(config_valid), .boot_from_flash(boot_from_flash),
		.sdio_in_rising(sdio_in_rising), .sdio_out_rising(sdio_out_rising),
		.sdio_edge_apply(sdio_edge_apply), .uart_boot_msg_en(uart_boot_msg_en),
		.sdio_volt_1v8(sdio_volt_1v8), .strap_error(strap_error), .route_sdio(route_sdio),
		.route_spi(route_spi), .route_gpio(route_gpio));
	initial
	begin
		forever #2.5 clk = ~clk;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic go(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : go
	// reset held 16 cycles with straps applied, then a few edges for capture
	task automatic boot(input logic en, input bscl_straps_type s);
		go(1);
		nrst = 0;
		drv_en = en;
		drv = s;
		go(16);
		check({4'h0, route_sdio, route_spi, route_gpio, config_valid}, 8'h02);
		nrst = 1;
		go(4);
	endtask : boot
	task automatic t_timing;
		for (int i = 0; i < 4; i++)
		begin
			boot(1, {2'h3, i[1], i[0], 1'h0});
			check(outs, {1'b0, 2'h3, i[0], i[1], i[0], 2'h0});
		end
	endtask : t_timing
	task automatic t_faults;
		boot(1, 5'h0e);
		check(outs, 8'h5d);
		boot(1, 5'h1f);
		check(outs, 8'h7d);
		boot(0, '0);
		check(outs, 8'h7c);
	endtask : t_faults
	task automatic t_hold;
		boot(1, 5'h12);
		drv = 5'h09;
		go(6);
		check(outs, 8'h55);
	endtask : t_hold
	task automatic t_apply;
		check({7'h0, sdio_edge_apply}, 8'h00);
		boot_active = 1;
		#1;
		check({7'h0, sdio_edge_apply}, 8'h01);
		go(1);
		boot_active = 0;
		#1;
		check({7'h0, sdio_edge_apply}, 8'h00);
		go(1);
	endtask : t_apply
	// back-to-back commands; code 3 must leave the routing alone
	task automatic t_route;
		logic [1:0] seq [5] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h3};
		logic [2:0] want [5] = '{3'h2, 3'h4, 3'h4, 3'h1, 3'h1};
		fn_sel_valid = 1;
		for (int i = 0; i < 5; i++)
		begin
			fn_sel = seq[i];
			go(1);
			check({5'h0, route_gpio, route_spi, route_sdio}, {5'h0, want[i]});
		end
		fn_sel_valid = 0;
	endtask : t_route
	// a command offered while the clock enable is low must wait for it
	task automatic t_freeze;
		go(1);
		ce = 0;
		fn_sel_valid = 1;
		fn_sel = 2'h1;
		go(2);
		check({5'h0, route_gpio, route_spi, route_sdio}, 8'h01);
		check(outs, 8'h55);
		ce = 1;
		go(1);
		check({5'h0, route_gpio, route_spi, route_sdio}, 8'h02);
		fn_sel_valid = 0;
	endtask : t_freeze
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		#20000;
		err_total++;
		tally_and_finish();
	end
	initial
	begin
		t_timing();
		t_faults();
		t_hold();
		t_apply();
		t_route();
		t_freeze();
		tally_and_finish();
	end
endmodule : bscl_top_bench
`default_nettype wire
